// File: wdog_chk_sva.sv
/* Concurrent checks on the watchdog ports.
   Assumes it is bound onto windowed_watchdog_timer, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module wdog_chk (
	input wire logic        CLK,
	input wire logic        ARST_N,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic        SYS_RESET_REQ,
	input wire logic        IRQ
);
	// ========================================
	// Access decode
	wire logic acc_wr = PSEL && PENABLE && PWRITE;
	wire logic acc_rd = PSEL && PENABLE && !PWRITE;
	default clocking @(posedge CLK); endclocking
	default disable iff (!ARST_N);
	// ========================================
	// Properties; no wait states, so every access phase is the answer
	ready_high_a: assert property (PREADY) else $error("ready low");
	no_slverr_a: assert property (!PSLVERR) else $error("slave error seen");
	bad_key_a: assert property (acc_wr && PADDR == 12'h000 && PWDATA != 32'h55 &&
		PWDATA != 32'hAA |=> SYS_RESET_REQ) else $error("bad key kept running");
	status_zero_a: assert property (acc_rd && PADDR == 12'h000 |-> PRDATA == 32'h0)
		else $error("status read not zero");
	opt2_bits_a: assert property (acc_rd && PADDR == 12'h008 |-> PRDATA[31:8] == 24'h0)
		else $error("options two high bits set");
	unmapped_zero_a: assert property (acc_rd && PADDR > 12'h014 |-> PRDATA == 32'h0)
		else $error("unmapped read not zero");
	irq_sticky_a: assert property (IRQ && !acc_wr && !$past(acc_wr) |=> IRQ)
		else $error("irq dropped alone");
	quiet_start_a: assert property ($rose(ARST_N) |-> !SYS_RESET_REQ [*2])
		else $error("reset request right after reset");
endmodule
bind windowed_watchdog_timer wdog_chk chk (.CLK(CLK), .ARST_N(ARST_N), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .SYS_RESET_REQ(SYS_RESET_REQ), .IRQ(IRQ));
`default_nettype wire

// File: wdog_consts.vh
/*
 * Constants of the windowed watchdog: APB register offsets, field positions,
 * reset values, servicing keys and timing counts.
 * Assumes inclusion by bare name from the watchdog design file.
 */
`ifndef WDOG_CONSTS_VH
`define WDOG_CONSTS_VH

// =============================================================
// Register byte offsets
`define OFS_RESET_STATUS   12'h000
`define OFS_SYS_OPTIONS_ONE 12'h004
`define OFS_SYS_OPTIONS_TWO 12'h008
`define OFS_IRQ_STATUS     12'h00C
`define OFS_IRQ_MASK       12'h010
`define OFS_WD_STATE       12'h014

// =============================================================
// Fields and reset values
`define TSEL_LSB           0
`define CLKSEL_BIT         7
`define WINEN_BIT          6
`define TSEL_RESET         2'h3
`define OPT2_RESET         8'h00

// =============================================================
// Servicing keys
`define KEY_FIRST          8'h55
`define KEY_SECOND         8'hAA

// =============================================================
// Timing
`define CLK_HZ             50000000
`define SLOW_HZ            1000
`define SLOW_DIV           (`CLK_HZ / `SLOW_HZ)
`define CNT_W              18

// Interrupt status bits
`define EV_SERVICED        0
`define EV_BAD_KEY         1
`define EV_EARLY           2
`define EV_TIMEOUT         3

`endif

// File: windowed_watchdog_timer.v
/*
 * Windowed watchdog timer with an APB register slave. Software services it by
 * writing two keys to the reset status address; missing, wrong or early
 * servicing raises a system reset request; a bus-clock overflow holds it until reset.
 * Assumes CLK is the bus clock at 50 MHz and that the system reset it drives
 * comes back as ARST_N; the 1 kHz tick is derived from CLK by a divider.
 */
`timescale 1ns/1ps
`default_nettype none
`include "wdog_consts.vh"

// Functional notes
// - Watchdog enabled after every reset
// - Timeout select zero disables the watchdog; a bad key still requests reset
// - Status writes never change read contents; IRQ status is write-one-to-clear
// - Completed sequence restarts timeout period
// - Overflow without servicing forces system reset
// - Any other key value resets immediately
// - Bit 7 selects bus or 1 kHz
// - Reset defaults: 1 kHz, longest timeout
// - Slow source overflows at 2^5/2^8/2^10
// - Bus source overflows at 2^13/2^16/2^18
// - Window mode accepts only last quarter
// - Early write in window mode resets
// - Window opens at 6144/49152/196608 cycles
// - No window mode with slow source
// - Clock and window bits write once
module windowed_watchdog_timer #(
	parameter SLOW_DIV = `SLOW_DIV
) (
	input  wire        CLK,
	input  wire        ARST_N,
	input  wire        PSEL,
	input  wire        PENABLE,
	input  wire        PWRITE,
	input  wire [11:0] PADDR,
	input  wire [31:0] PWDATA,
	output reg  [31:0] PRDATA,
	output reg         PREADY,
	output reg         PSLVERR,
	output reg         SYS_RESET_REQ,
	output reg         IRQ
);

	// =============================================================
	// Overflow and window thresholds
	function [`CNT_W:0] overflow_of;
		input [1:0] tsel;
		input       bus;
		begin
			case ({bus, tsel})
				3'h1:    overflow_of = 19'h00020;
				3'h2:    overflow_of = 19'h00100;
				3'h3:    overflow_of = 19'h00400;
				3'h5:    overflow_of = 19'h02000;
				3'h6:    overflow_of = 19'h10000;
				3'h7:    overflow_of = 19'h40000;
				default: overflow_of = 19'h7FFFF;
			endcase
		end
	endfunction

	// Three quarters of the overflow count
	function [`CNT_W:0] window_of;
		input [1:0] tsel;
		begin
			case (tsel)
				2'h1:    window_of = 19'h01800;
				2'h2:    window_of = 19'h0C000;
				2'h3:    window_of = 19'h30000;
				default: window_of = 19'h00000;
			endcase
		end
	endfunction

	// =============================================================
	// Registers
	reg [1:0]        tsel_q;
	reg              clksel_q;
	reg              winen_q;
	reg              opt2_done_q;
	reg [`CNT_W:0]   cnt_q;
	reg [31:0]       div_q;
	reg              key1_q;
	reg [3:0]        irq_sts_q;
	reg [3:0]        irq_msk_q;

	wire             wr_en = PSEL & PENABLE & PWRITE;
	wire             rd_en = PSEL & PENABLE & ~PWRITE;
	wire             enabled = (tsel_q != 2'h0);
	wire             win_mode = winen_q & clksel_q;
	wire             slow_tick = (div_q == SLOW_DIV - 1);
	wire             tick = clksel_q | slow_tick;
	wire             svc_wr = wr_en & (PADDR == `OFS_RESET_STATUS);
	wire [7:0]       key = PWDATA[7:0];
	wire             key_ok = (PWDATA[31:8] == 24'h000000) &
	                          ((key == `KEY_FIRST) | (key == `KEY_SECOND));
	wire             early = win_mode & (cnt_q < window_of(tsel_q));
	wire             bad_key = svc_wr & ~key_ok;
	wire             early_hit = svc_wr & enabled & early;
	wire             serviced = svc_wr & key_ok & ~early & key1_q &
	                            (key == `KEY_SECOND);
	wire             overflow = enabled & tick &
	                            (cnt_q + 19'h00001 >= overflow_of(tsel_q, clksel_q));
	wire [3:0]       events = {overflow, early_hit, bad_key, serviced};

	// Single-cycle APB: no wait states, no errors; flopped so every output is a register
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			PREADY  <= 1'b1;
			PSLVERR <= 1'b0;
		end else begin
			PREADY  <= 1'b1;
			PSLVERR <= 1'b0;
		end
	end

	// =============================================================
	// Configuration; timeout select is writable any time
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			tsel_q      <= `TSEL_RESET;
			clksel_q    <= 1'b0;
			winen_q     <= 1'b0;
			opt2_done_q <= 1'b0;
			irq_msk_q   <= 4'h0;
		end else if (wr_en) begin
			if (PADDR == `OFS_SYS_OPTIONS_ONE)
				tsel_q <= PWDATA[`TSEL_LSB+1:`TSEL_LSB];
			if (PADDR == `OFS_SYS_OPTIONS_TWO && !opt2_done_q) begin
				// Locked after the first write so runaway code cannot weaken it
				clksel_q    <= PWDATA[`CLKSEL_BIT];
				winen_q     <= PWDATA[`WINEN_BIT];
				opt2_done_q <= 1'b1;
			end
			if (PADDR == `OFS_IRQ_MASK)
				irq_msk_q <= PWDATA[3:0];
		end
	end

	// =============================================================
	// Slow tick divider, free running off the bus clock
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N)
			div_q <= 32'h00000000;
		else if (slow_tick)
			div_q <= 32'h00000000;
		else
			div_q <= div_q + 32'h00000001;
	end

	// =============================================================
	// Counter and servicing tracker
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			cnt_q  <= {(`CNT_W+1){1'b0}};
			key1_q <= 1'b0;
		end else if (serviced) begin
			cnt_q  <= {(`CNT_W+1){1'b0}};
			key1_q <= 1'b0;
		end else begin
			if (!enabled)
				cnt_q <= {(`CNT_W+1){1'b0}};
			else if (tick)
				cnt_q <= cnt_q + 19'h00001;
			// First key arms, anything else disarms the sequence
			if (svc_wr)
				key1_q <= key_ok & (key == `KEY_FIRST);
		end
	end

	// =============================================================
	// System reset request; high each cycle a fault is seen, so a bus-clock overflow holds it until the reset clears us
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N)
			SYS_RESET_REQ <= 1'b0;
		else
			SYS_RESET_REQ <= overflow | bad_key | early_hit;
	end

	// =============================================================
	// Sticky interrupt status; set wins over write-one-to-clear
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N)
			irq_sts_q <= 4'h0;
		else if (wr_en && PADDR == `OFS_IRQ_STATUS)
			irq_sts_q <= (irq_sts_q & ~PWDATA[3:0]) | events;
		else
			irq_sts_q <= irq_sts_q | events;
	end

	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N)
			IRQ <= 1'b0;
		else
			IRQ <= |(irq_sts_q & ~irq_msk_q);           // Mask bit high hides its event
	end

	// =============================================================
	// Read data, registered at the setup cycle so it is valid in access
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N)
			PRDATA <= 32'h00000000;
		else if (PSEL && !PENABLE && !PWRITE) begin
			case (PADDR)
				// Reset status reads zero; writes there only service
				`OFS_RESET_STATUS:    PRDATA <= 32'h00000000;
				`OFS_SYS_OPTIONS_ONE: PRDATA <= {30'h00000000, tsel_q};
				`OFS_SYS_OPTIONS_TWO: PRDATA <= {24'h000000, clksel_q, winen_q, 6'h00};
				`OFS_IRQ_STATUS:      PRDATA <= {28'h0000000, irq_sts_q};
				`OFS_IRQ_MASK:        PRDATA <= {28'h0000000, irq_msk_q};
				`OFS_WD_STATE:        PRDATA <= {12'h000, key1_q, cnt_q};
				default:              PRDATA <= 32'h00000000;
			endcase
		end
	end

	// Read enable kept for clarity of access qualification
	wire unused_rd = rd_en;

endmodule
`default_nettype wire

// File: windowed_watchdog_timer_tb.sv
/* Self-checking bench for the windowed watchdog.
   Assumes the bench itself plays the system reset that SYS_RESET_REQ asks for. */
`timescale 1ns/1ps
`default_nettype none
module windowed_watchdog_timer_tb;
	logic        CLK = 0, ARST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
	logic [11:0] PADDR = 12'h000;
	logic [31:0] PWDATA = 32'h0, rnd;
	wire  [31:0] PRDATA;
	wire         PREADY, PSLVERR, SYS_RESET_REQ, IRQ;
	logic [31:0] exp_q[$];
	int          miscompares = 0, checks_done = 0, rst_cnt = 0, seed = 70, n0, i;
	// Short slow divider keeps the 1 kHz timeouts cheap
	windowed_watchdog_timer #(.SLOW_DIV(4)) dut (.CLK(CLK), .ARST_N(ARST_N), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
		.PREADY(PREADY), .PSLVERR(PSLVERR), .SYS_RESET_REQ(SYS_RESET_REQ), .IRQ(IRQ));
	always #10 CLK = ~CLK;
	// ========================================
	// Tasks
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One APB transfer; a read notes its expected data for the monitor
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		if (!w) exp_q.push_back(d);
		@(posedge CLK);
		PENABLE <= 1'b1;
		@(posedge CLK);
		while (PREADY !== 1'b1) @(posedge CLK);
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	task do_reset;
		@(posedge CLK);
		ARST_N <= 1'b0;
		repeat (6) @(posedge CLK);
		ARST_N <= 1'b1;
	endtask
	// Quiet for q cycles, then one request within w; counts read off-edge to avoid races
	task fire(input int q, input int w);
		n0 = rst_cnt;
		repeat (q) @(negedge CLK);
		chk("quiet", n0, rst_cnt);
		repeat (w) if (rst_cnt == n0) @(negedge CLK);
		chk("fire", n0 + 1, rst_cnt);
		do_reset;
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Monitor: read data against the oldest note, reset requests counted
	always @(posedge CLK) begin
		if (SYS_RESET_REQ === 1'b1) rst_cnt++;
		if (PSEL && PENABLE && !PWRITE && PREADY) chk("prdata", exp_q.pop_front(), PRDATA);
	end
	// ========================================
	// Scenarios
	initial begin
		do_reset;
		apb(0, 12'h004, 32'h3);
		apb(0, 12'h008, 32'h0);
		apb(0, 12'h100, 32'h0);
		apb(1, 12'h000, 32'hAA);
		apb(0, 12'h000, 32'h0);
		fire(3900, 400);
		apb(1, 12'h004, 32'h1);
		apb(1, 12'h008, 32'h40);
		apb(1, 12'h000, 32'h55);
		apb(1, 12'h000, 32'hAA);
		fire(100, 60);
		apb(1, 12'h010, 32'h0);
		for (i = 0; i < 3; i++) begin
			rnd = $random(seed) | 32'h100;
			n0 = rst_cnt;
			apb(1, 12'h000, rnd);
			apb(0, 12'h00C, 32'h2);
			chk("req", n0 + 1, rst_cnt);
		end
		chk("irq", 1'b1, IRQ);
		apb(1, 12'h010, 32'h2);
		repeat (2) @(negedge CLK);
		chk("irq", 1'b0, IRQ);
		apb(1, 12'h010, 32'h0);
		apb(1, 12'h00C, 32'h2);
		repeat (2) @(negedge CLK);
		chk("irq", 1'b0, IRQ);
		do_reset;
		apb(1, 12'h004, 32'h1);
		apb(1, 12'h008, 32'h80);
		apb(1, 12'h008, 32'h40);
		apb(0, 12'h008, 32'h80);
		repeat (5000) @(posedge CLK);
		apb(1, 12'h000, 32'h55);
		apb(1, 12'h000, 32'hAA);
		fire(8100, 150);
		apb(1, 12'h004, 32'h1);
		apb(1, 12'h008, 32'hC0);
		apb(1, 12'h000, 32'h55);
		fire(0, 4);
		apb(1, 12'h004, 32'h1);
		apb(1, 12'h008, 32'hC0);
		repeat (6200) @(posedge CLK);
		apb(1, 12'h000, 32'h55);
		apb(1, 12'h000, 32'hAA);
		fire(8100, 150);
		apb(1, 12'h004, 32'h0);
		n0 = rst_cnt;
		repeat (5000) @(negedge CLK);
		chk("off", n0, rst_cnt);
		end_of_test;
	end
	// Watchdog on the bench itself
	initial begin
		#1500000;
		miscompares++;
		end_of_test;
	end
endmodule
`default_nettype wire
